// ===== hw/match_detector.v
// Compare match detector: one pulse when a counter comes to equal its
// compare value. Counter and compare come from logic on core_clk.
`timescale 1ns/1ps
`default_nettype none

module match_detector #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // Values to compare
    input wire [WIDTH-1:0] count,
    input wire [WIDTH-1:0] compare,
    // One-cycle match event
    output wire match
);

    wire equalNow;
    reg equal_q;

    assign equalNow = (count == compare);

    // Only the first cycle of equality counts as one match
    assign match = equalNow & ~equal_q;

    always @(posedge core_clk) begin
        if (reset) begin
            equal_q <= 1'b0;
        end else begin
            equal_q <= equalNow;
        end
    end

endmodule // match_detector

`default_nettype wire

// ===== hw/timer_channel_flags.v
// Sticky event flags of one timer channel, in either layout.
// Event inputs are one-cycle pulses from logic on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "timer_flags_defines.vh"

module timer_channel_flags #(
    parameter HAS_UPDOWN = 1
) (
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // Layout select
    input wire updownMode,
    // Normal timer events
    input wire matchA,
    input wire matchB,
    input wire upOverflow,
    // Two-phase counter events
    input wire udOverflow,
    input wire udUnderflow,
    input wire countStep,
    // Status register read
    input wire readClear,
    // Flags
    output wire [7:0] flags
);

    reg [7:0] flags_q;
    reg [7:0] flags_d;
    reg [7:0] setVec;
    reg mode_q;
    wire modeNow;

    assign modeNow = (HAS_UPDOWN != 0) & updownMode;
    assign flags = flags_q;

    always @* begin
        setVec = 8'h00;
        if (modeNow) begin
            setVec[`UD_OVF_BIT] = udOverflow; // [R5] [R6]
            setVec[`UD_UNF_BIT] = udUnderflow; // [R7]
            setVec[`UD_STEP_BIT] = countStep; // [R8]
        end else begin
            setVec[`CMPA_MATCH_BIT] = matchA; // [R1] [R4]
            setVec[`CMPB_MATCH_BIT] = matchB; // [R2]
            setVec[`UP_OVF_BIT] = upOverflow; // [R3]
        end
        // Read clears what it returned; a new event still lands
        if (readClear || (modeNow != mode_q)) begin
            flags_d = setVec; // [R10]
        end else begin
            flags_d = flags_q | setVec; // [R9] [R10]
        end
    end

    always @(posedge core_clk) begin
        if (reset) begin
            flags_q <= `FLAGS_RESET; // [R9]
            mode_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            mode_q <= modeNow;
        end
    end

endmodule // timer_channel_flags

`default_nettype wire

// ===== hw/timer_event_status_flags.v
// Event status flags of timer units 1, 2 and 3, with run control,
// interrupt masks and one level interrupt.
// Assumes counters, compare registers and event pulses from logic on
// core_clk, and a register master that never issues read and write at once.
`timescale 1ns/1ps
`default_nettype none
`include "timer_flags_defines.vh"

// How it works
// R1 - In normal mode bit 0 sets when the up-counter reaches compare value A.
// R2 - In normal mode bit 1 sets when the up-counter reaches compare value B.
// R3 - In normal mode bit 2 sets when the up-counter overflows.
// R4 - Units 2 and 3 with the up-down enable at 0 use the normal layout.
// R5 - Units 2 and 3 with the up-down enable at 1 use the two-phase layout.
// R6 - In two-phase mode bit 2 sets on up-down counter overflow.
// R7 - In two-phase mode bit 3 sets on up-down counter underflow.
// R8 - In two-phase mode bit 4 sets on every count step up or down.
// R9 - A flag reads 1 once its event is seen, is read-only and resets to 0.
// R10 - Flags stay until a status read or a layout change, which clear them but keep new events.
module timer_event_status_flags #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // Register port
    input wire [31:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output wire [31:0] regRdData,
    // Unit 1 counter side
    input wire [WIDTH-1:0] upCount1,
    input wire [WIDTH-1:0] timer1_compare_a,
    input wire [WIDTH-1:0] timer1_compare_b,
    input wire upOverflow1,
    // Unit 2 counter side
    input wire [WIDTH-1:0] upCount2,
    input wire [WIDTH-1:0] timer2_compare_a,
    input wire [WIDTH-1:0] timer2_compare_b,
    input wire upOverflow2,
    input wire udOverflow2,
    input wire udUnderflow2,
    input wire countStep2,
    // Unit 3 counter side
    input wire [WIDTH-1:0] upCount3,
    input wire [WIDTH-1:0] timer3_compare_a,
    input wire [WIDTH-1:0] timer3_compare_b,
    input wire upOverflow3,
    input wire udOverflow3,
    input wire udUnderflow3,
    input wire countStep3,
    // Mode to the counters
    output wire timer2_updown_enable,
    output wire timer3_updown_enable,
    // Interrupt
    output wire timerIrq
);

    // Address decode
    wire hitFlags1;
    wire hitFlags2;
    wire hitFlags3;
    wire hitRun2;
    wire hitRun3;
    wire hitMask1;
    wire hitMask2;
    wire hitMask3;

    assign hitFlags1 = (regAddr == `T1_FLAGS_ADDR);
    assign hitFlags2 = (regAddr == `T2_FLAGS_ADDR);
    assign hitFlags3 = (regAddr == `T3_FLAGS_ADDR);
    assign hitRun2 = (regAddr == `T2_RUN_ADDR);
    assign hitRun3 = (regAddr == `T3_RUN_ADDR);
    assign hitMask1 = (regAddr == `T1_MASK_ADDR);
    assign hitMask2 = (regAddr == `T2_MASK_ADDR);
    assign hitMask3 = (regAddr == `T3_MASK_ADDR);

    // Software registers
    reg updown2_q;
    reg updown3_q;
    reg [7:0] mask1_q;
    reg [7:0] mask2_q;
    reg [7:0] mask3_q;
    reg [31:0] rdData_q;
    reg [31:0] rdData_d;

    // Flag outputs of the channels
    wire [7:0] flags1;
    wire [7:0] flags2;
    wire [7:0] flags3;

    // Match events
    wire matchA1;
    wire matchB1;
    wire matchA2;
    wire matchB2;
    wire matchA3;
    wire matchB3;

    // Status reads clear their channel
    wire readFlags1;
    wire readFlags2;
    wire readFlags3;

    // Mask bits that reads and the interrupt see follow the current layout
    wire [7:0] maskBits2;
    wire [7:0] maskBits3;

    // Layout of units 2 and 3 as their flags last saw it
    reg layout2_q;
    reg layout3_q;
    wire layoutFresh2;
    wire layoutFresh3;
    // Flags as software and the interrupt see them
    wire [7:0] flagsView2;
    wire [7:0] flagsView3;

    // Interrupt request of each unit
    wire irq1;
    wire irq2;
    wire irq3;

    // Register write enables
    wire wrRun2;
    wire wrRun3;
    wire wrMask1;
    wire wrMask2;
    wire wrMask3;

    assign readFlags1 = regRead & hitFlags1; // [R10]
    assign readFlags2 = regRead & hitFlags2; // [R10]
    assign readFlags3 = regRead & hitFlags3; // [R10]

    assign maskBits2 = updown2_q ? `MASK_UPDOWN : `MASK_NORMAL;
    assign maskBits3 = updown3_q ? `MASK_UPDOWN : `MASK_NORMAL;

    assign timer2_updown_enable = updown2_q;
    assign timer3_updown_enable = updown3_q;

    assign wrRun2 = regWrite & hitRun2;
    assign wrRun3 = regWrite & hitRun3;
    assign wrMask1 = regWrite & hitMask1;
    assign wrMask2 = regWrite & hitMask2;
    assign wrMask3 = regWrite & hitMask3;

    // Channels clear old-layout flags one edge after a mode write;
    // hide them in that cycle so no read or interrupt sees them
    assign layoutFresh2 = (updown2_q != layout2_q); // [R5]
    assign layoutFresh3 = (updown3_q != layout3_q); // [R5]
    assign flagsView2 = layoutFresh2 ? 8'h00 : flags2; // [R4] [R5]
    assign flagsView3 = layoutFresh3 ? 8'h00 : flags3; // [R4] [R5]

    // Compare match detection
    match_detector #(
        .WIDTH(WIDTH)
    ) u_match_a1 (
        .core_clk(core_clk),
        .reset(reset),
        .count(upCount1),
        .compare(timer1_compare_a),
        .match(matchA1)
    ); // [R1]

    match_detector #(
        .WIDTH(WIDTH)
    ) u_match_b1 (
        .core_clk(core_clk),
        .reset(reset),
        .count(upCount1),
        .compare(timer1_compare_b),
        .match(matchB1)
    ); // [R2]

    match_detector #(
        .WIDTH(WIDTH)
    ) u_match_a2 (
        .core_clk(core_clk),
        .reset(reset),
        .count(upCount2),
        .compare(timer2_compare_a),
        .match(matchA2)
    ); // [R1]

    match_detector #(
        .WIDTH(WIDTH)
    ) u_match_b2 (
        .core_clk(core_clk),
        .reset(reset),
        .count(upCount2),
        .compare(timer2_compare_b),
        .match(matchB2)
    ); // [R2]

    match_detector #(
        .WIDTH(WIDTH)
    ) u_match_a3 (
        .core_clk(core_clk),
        .reset(reset),
        .count(upCount3),
        .compare(timer3_compare_a),
        .match(matchA3)
    ); // [R1]

    match_detector #(
        .WIDTH(WIDTH)
    ) u_match_b3 (
        .core_clk(core_clk),
        .reset(reset),
        .count(upCount3),
        .compare(timer3_compare_b),
        .match(matchB3)
    ); // [R2]

    // Unit 1 has no two-phase mode
    timer_channel_flags #(
        .HAS_UPDOWN(0)
    ) u_flags1 (
        .core_clk(core_clk),
        .reset(reset),
        .updownMode(1'b0),
        .matchA(matchA1),
        .matchB(matchB1),
        .upOverflow(upOverflow1),
        .udOverflow(1'b0),
        .udUnderflow(1'b0),
        .countStep(1'b0),
        .readClear(readFlags1),
        .flags(flags1)
    ); // [R3]

    timer_channel_flags #(
        .HAS_UPDOWN(1)
    ) u_flags2 (
        .core_clk(core_clk),
        .reset(reset),
        .updownMode(updown2_q),
        .matchA(matchA2),
        .matchB(matchB2),
        .upOverflow(upOverflow2),
        .udOverflow(udOverflow2),
        .udUnderflow(udUnderflow2),
        .countStep(countStep2),
        .readClear(readFlags2),
        .flags(flags2)
    ); // [R4] [R5]

    timer_channel_flags #(
        .HAS_UPDOWN(1)
    ) u_flags3 (
        .core_clk(core_clk),
        .reset(reset),
        .updownMode(updown3_q),
        .matchA(matchA3),
        .matchB(matchB3),
        .upOverflow(upOverflow3),
        .udOverflow(udOverflow3),
        .udUnderflow(udUnderflow3),
        .countStep(countStep3),
        .readClear(readFlags3),
        .flags(flags3)
    ); // [R4] [R5]

    // Register writes; status registers ignore writes
    always @(posedge core_clk) begin
        if (reset) begin
            updown2_q <= 1'b0; // [R4]
            updown3_q <= 1'b0; // [R4]
            mask1_q <= `MASK_RESET;
            mask2_q <= `MASK_RESET;
            mask3_q <= `MASK_RESET;
        end else begin
            if (wrRun2) begin
                updown2_q <= regWrData[`UPDOWN_EN_BIT]; // [R5]
            end
            if (wrRun3) begin
                updown3_q <= regWrData[`UPDOWN_EN_BIT]; // [R5]
            end
            if (wrMask1) begin
                mask1_q <= regWrData[7:0] & `MASK_NORMAL;
            end
            if (wrMask2) begin
                mask2_q <= regWrData[7:0];
            end
            if (wrMask3) begin
                mask3_q <= regWrData[7:0];
            end
        end
    end

    // Read data mux, unmapped reads give zero
    always @* begin
        rdData_d = 32'h00000000;
        if (regRead) begin
            if (hitFlags1) begin
                rdData_d = {24'h000000, flags1}; // [R9]
            end else if (hitFlags2) begin
                rdData_d = {24'h000000, flagsView2}; // [R9]
            end else if (hitFlags3) begin
                rdData_d = {24'h000000, flagsView3}; // [R9]
            end else if (hitRun2) begin
                rdData_d[`UPDOWN_EN_BIT] = updown2_q;
            end else if (hitRun3) begin
                rdData_d[`UPDOWN_EN_BIT] = updown3_q;
            end else if (hitMask1) begin
                rdData_d = {24'h000000, mask1_q};
            end else if (hitMask2) begin
                rdData_d = {24'h000000, mask2_q & maskBits2};
            end else if (hitMask3) begin
                rdData_d = {24'h000000, mask3_q & maskBits3};
            end
        end
    end

    // Read data stands only in the cycle after the read strobe
    always @(posedge core_clk) begin
        if (reset) begin
            rdData_q <= 32'h00000000;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    // Follows the mode registers one edge behind, like the channels
    always @(posedge core_clk) begin
        if (reset) begin
            layout2_q <= 1'b0;
            layout3_q <= 1'b0;
        end else begin
            layout2_q <= updown2_q;
            layout3_q <= updown3_q;
        end
    end

    assign regRdData = rdData_q;

    assign irq1 = |(flags1 & mask1_q);
    assign irq2 = |(flagsView2 & mask2_q & maskBits2);
    assign irq3 = |(flagsView3 & mask3_q & maskBits3);

    // Level interrupt while any unmasked flag is set
    assign timerIrq = irq1 | irq2 | irq3;

endmodule // timer_event_status_flags

`default_nettype wire

// ===== hw/timer_flags_defines.vh
// Constants for the timer event flag block: addresses, bit positions,
// reset values. Assumes a 32-bit byte address on the register port.
`ifndef TIMER_FLAGS_DEFINES_VH
`define TIMER_FLAGS_DEFINES_VH

// Status registers, read-only, read clears
`define T1_FLAGS_ADDR 32'hFFFFF154
`define T2_FLAGS_ADDR 32'hFFFFF164
`define T3_FLAGS_ADDR 32'hFFFFF174

// Run control of units 2 and 3
`define T2_RUN_ADDR 32'hFFFFF1F0
`define T3_RUN_ADDR 32'hFFFFF1F4

// Interrupt masks, same layout as the status registers
`define T1_MASK_ADDR 32'hFFFFF1E0
`define T2_MASK_ADDR 32'hFFFFF1E4
`define T3_MASK_ADDR 32'hFFFFF1E8

// Run control field
`define UPDOWN_EN_BIT 1

// Status fields, normal timer layout
`define CMPA_MATCH_BIT 0
`define CMPB_MATCH_BIT 1
`define UP_OVF_BIT 2

// Status fields, two-phase counter layout
`define UD_OVF_BIT 2
`define UD_UNF_BIT 3
`define UD_STEP_BIT 4

// Mask bits that reads and the interrupt see per layout; unit 1 stores only the normal set
`define MASK_NORMAL 8'h07
`define MASK_UPDOWN 8'h1C

// Reset values
`define FLAGS_RESET 8'h00
`define MASK_RESET 8'h00
`define RUN_RESET 8'h00

`endif

// ===== verif/timer_event_status_flags_asserts.sv
// Port assertions for the timer event flag block.
// Assumes the register master keeps the one-cycle strobe contract.
`timescale 1ns/1ps
`default_nettype none
`include "timer_flags_defines.vh"

module timer_event_status_flags_asserts #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register port
    input wire logic [31:0] regAddr,
    input wire logic regRead,
    input wire logic [31:0] regRdData,
    // Counter side
    input wire logic [WIDTH-1:0] upCount1,
    input wire logic [WIDTH-1:0] timer1_compare_a,
    input wire logic [WIDTH-1:0] timer1_compare_b,
    input wire logic upOverflow1,
    input wire logic upOverflow2,
    input wire logic udOverflow2,
    input wire logic udUnderflow2,
    input wire logic countStep2,
    // Mode and interrupt
    input wire logic timer2_updown_enable,
    input wire logic timerIrq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    wire rd1 = regRead && regAddr == `T1_FLAGS_ADDR;
    wire rd2 = regRead && regAddr == `T2_FLAGS_ADDR;
    wire eqA = upCount1 == timer1_compare_a;
    wire eqB = upCount1 == timer1_compare_b;
    wire ud2 = timer2_updown_enable;

    property p_rd_idle;
        !regRead |=> regRdData == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_rd_upper;
        regRead |=> regRdData[31:8] == 24'h0;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("upper bits set");
    property p_cmpa;
        (eqA && !$past(eqA)) ##1 rd1 |=> regRdData[0];
    endproperty
    a_cmpa: assert property (p_cmpa) else $error("compare A flag missing");
    property p_cmpb;
        (eqB && !$past(eqB)) ##1 rd1 |=> regRdData[1];
    endproperty
    a_cmpb: assert property (p_cmpb) else $error("compare B flag missing");
    property p_ovf1;
        upOverflow1 ##1 rd1 |=> regRdData[2];
    endproperty
    a_ovf1: assert property (p_ovf1) else $error("overflow flag missing");
    property p_norm2;
        (upOverflow2 && !ud2) ##1 (rd2 && !ud2) |=> regRdData[2];
    endproperty
    a_norm2: assert property (p_norm2) else $error("normal layout flag missing");
    property p_layout2;
        rd2 && ud2 |=> regRdData[1:0] == 2'b00 && regRdData[7:5] == 3'b000;
    endproperty
    a_layout2: assert property (p_layout2) else $error("bad two-phase layout");
    property p_udovf;
        (udOverflow2 && ud2) ##1 (rd2 && ud2) |=> regRdData[2];
    endproperty
    a_udovf: assert property (p_udovf) else $error("up-down overflow missing");
    property p_udunf;
        (udUnderflow2 && ud2) ##1 (rd2 && ud2) |=> regRdData[3];
    endproperty
    a_udunf: assert property (p_udunf) else $error("underflow missing");
    property p_step;
        (countStep2 && ud2) ##1 (rd2 && ud2) |=> regRdData[4];
    endproperty
    a_step: assert property (p_step) else $error("count step missing");
    property p_keep;
        (rd1 && !upOverflow1) ##1 !upOverflow1 ##1 rd1 |=> !regRdData[2];
    endproperty
    a_keep: assert property (p_keep) else $error("flag not cleared");

    c_irq: cover property (timerIrq);
    c_mode_read: cover property (rd2 && ud2);
    c_set_wins: cover property (rd1 && upOverflow1);
endmodule // timer_event_status_flags_asserts
`default_nettype wire

// ===== verif/timer_event_status_flags_bench.sv
// Bench for the timer event flag block: reset and match cases, then the
// event table, then refusal, clear, mask and mid-run reset cases. Needs the hw defines header.
`timescale 1ns/1ps
`default_nettype none
`include "timer_flags_defines.vh"

module timer_event_status_flags_bench;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [31:0] regAddr = 32'h0;
    logic [31:0] regWrData = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] cnt = 16'h0000;
    logic [15:0] cmpA = 16'h0005;
    logic [15:0] cmpB = 16'h0009;
    // Events: up1 up2 up3, ovf2 unf2 step2, ovf3 unf3 step3
    logic [8:0] evt = 9'h000;
    logic [31:0] d;
    wire [31:0] regRdData;
    wire en2, en3, irq;
    int n_mismatch = 0;
    int checked = 0;
    logic [1:0] mode [6] = '{2'b00, 2'b11, 2'b11, 2'b00, 2'b01, 2'b10};
    logic [8:0] ev [6] = '{9'h007, 9'h1F8, 9'h007, 9'h1F8, 9'h014, 9'h142};
    logic [7:0] x1 [6] = '{8'h04, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00};
    logic [7:0] x2 [6] = '{8'h04, 8'h1C, 8'h00, 8'h00, 8'h08, 8'h04};
    logic [7:0] x3 [6] = '{8'h04, 8'h1C, 8'h00, 8'h00, 8'h04, 8'h14};

    timer_event_status_flags DUT (
        .core_clk(core_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .upCount1(cnt), .timer1_compare_a(cmpA), .timer1_compare_b(cmpB),
        .upOverflow1(evt[0]),
        .upCount2(cnt), .timer2_compare_a(cmpA), .timer2_compare_b(cmpB),
        .upOverflow2(evt[1]), .udOverflow2(evt[3]), .udUnderflow2(evt[4]),
        .countStep2(evt[5]),
        .upCount3(cnt), .timer3_compare_a(cmpA), .timer3_compare_b(cmpB),
        .upOverflow3(evt[2]), .udOverflow3(evt[6]), .udUnderflow3(evt[7]),
        .countStep3(evt[8]),
        .timer2_updown_enable(en2), .timer3_updown_enable(en3), .timerIrq(irq)
    );

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("mismatches %0d of %0d checks", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge core_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        evt <= 9'h000;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask
    // Read data sampled in the one cycle it stands
    task rd(input logic [31:0] a, output logic [31:0] v);
        @(posedge core_clk);
        regRead <= 1'b1;
        regAddr <= a;
        evt <= 9'h000;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 v = regRdData;
    endtask
    task fire(input logic [8:0] v);
        @(posedge core_clk);
        evt <= v;
    endtask

    initial begin
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #1000000;
        n_mismatch++;
        results();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        rd(`T1_FLAGS_ADDR, d);
        chk(d, 32'h0);
        rd(`T3_FLAGS_ADDR, d);
        chk(d, 32'h0);
        chk({irq, en2, en3}, 32'h0);
        @(posedge core_clk) cnt <= 16'h0005;
        rd(`T1_FLAGS_ADDR, d);
        chk(d, 32'h01);
        @(posedge core_clk) cnt <= 16'h0009;
        rd(`T1_FLAGS_ADDR, d);
        chk(d, 32'h02);
        rd(`T2_FLAGS_ADDR, d);
        chk(d, 32'h03);
        rd(`T3_FLAGS_ADDR, d);
        chk(d, 32'h03);
        for (int i = 0; i < 6; i++) begin
            wr(`T2_RUN_ADDR, {30'h0, mode[i][0], 1'b0});
            wr(`T3_RUN_ADDR, {30'h0, mode[i][1], 1'b0});
            fire(ev[i]);
            rd(`T2_FLAGS_ADDR, d);
            chk(d, {24'h0, x2[i]});
            chk({en3, en2}, {30'h0, mode[i]});
            rd(`T3_FLAGS_ADDR, d);
            chk(d, {24'h0, x3[i]});
            rd(`T1_FLAGS_ADDR, d);
            chk(d, {24'h0, x1[i]});
        end
        fire(9'h002);
        wr(`T2_RUN_ADDR, 32'h2);
        rd(`T2_FLAGS_ADDR, d);
        chk(d, 32'h0);
        chk(en2, 1'b1);
        wr(`T1_FLAGS_ADDR, 32'hFF);
        rd(`T1_FLAGS_ADDR, d);
        chk(d, 32'h0);
        // Event in the same cycle as the clearing read
        fire(9'h001);
        @(posedge core_clk);
        regRead <= 1'b1;
        regAddr <= `T1_FLAGS_ADDR;
        @(posedge core_clk);
        regRead <= 1'b0;
        evt <= 9'h000;
        #1 chk(regRdData, 32'h04);
        rd(`T1_FLAGS_ADDR, d);
        chk(d, 32'h04);
        rd(`T1_FLAGS_ADDR, d);
        chk(d, 32'h0);
        wr(`T1_MASK_ADDR, 32'hFF);
        fire(9'h001);
        rd(`T1_MASK_ADDR, d);
        chk(d, 32'h07);
        chk(irq, 1'b1);
        rd(`T1_FLAGS_ADDR, d);
        chk(irq, 1'b0);
        wr(`T1_MASK_ADDR, 32'h0);
        fire(9'h001);
        rd(32'hFFFFF000, d);
        chk(d, 32'h0);
        chk(irq, 1'b0);
        rd(`T1_FLAGS_ADDR, d);
        chk(d, 32'h04);
        // Reset in mid-run with a flag, a mask and both modes set
        wr(`T1_MASK_ADDR, 32'h4);
        fire(9'h001);
        rd(`T1_MASK_ADDR, d);
        chk(d, 32'h04);
        chk(irq, 1'b1);
        @(posedge core_clk);
        reset <= 1'b1;
        cnt <= 16'h0000;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        #1 chk({irq, en2, en3}, 32'h0);
        rd(`T1_FLAGS_ADDR, d);
        chk(d, 32'h0);
        rd(`T1_MASK_ADDR, d);
        chk(d, 32'h0);
        // Mode write followed at once by a status read
        fire(9'h002);
        wr(`T2_RUN_ADDR, 32'h2);
        regRead <= 1'b1;
        regAddr <= `T2_FLAGS_ADDR;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 chk(regRdData, 32'h0);
        rd(`T2_FLAGS_ADDR, d);
        chk(d, 32'h0);
        results();
    end
endmodule // timer_event_status_flags_bench

bind timer_event_status_flags timer_event_status_flags_asserts #(.WIDTH(WIDTH)) checker_u (
    .core_clk(core_clk), .reset(reset), .regAddr(regAddr), .regRead(regRead),
    .regRdData(regRdData), .upCount1(upCount1), .timer1_compare_a(timer1_compare_a),
    .timer1_compare_b(timer1_compare_b), .upOverflow1(upOverflow1),
    .upOverflow2(upOverflow2), .udOverflow2(udOverflow2), .udUnderflow2(udUnderflow2),
    .countStep2(countStep2), .timer2_updown_enable(timer2_updown_enable),
    .timerIrq(timerIrq)
);
`default_nettype wire
